// [uefs_defs.svh]
// register offsets, field positions and reset values of the uart status block
`ifndef UEFS_DEFS_SVH
`define UEFS_DEFS_SVH
`define UEFS_OFF_DATA  8'h00
`define UEFS_OFF_RSR   8'h04
`define UEFS_OFF_FLAG  8'h18
`define UEFS_OFF_DIV   8'h24
`define UEFS_OFF_LCR   8'h2C
`define UEFS_OFF_ISTAT 8'h40
`define UEFS_OFF_IMASK 8'h44
// status and interrupt bit positions
`define UEFS_RSR_FRM 0
`define UEFS_RSR_PAR 1
`define UEFS_RSR_BRK 2
`define UEFS_RSR_OE 3
// line_control bit positions
`define UEFS_LCR_PEN 1
`define UEFS_LCR_EVEN 2
`define UEFS_LCR_FIFO 4
`define UEFS_LCR_WLO 5
`define UEFS_LCR_WHI 6
`define UEFS_LCR_STICK 7
// reset values
`define UEFS_LCR_RST 8'h00
`define UEFS_DIV_RST 16'h0010
`endif

// [uefs_pkg.sv]
// types and shared serial helpers of the uart status block
package uefs_pkg;
  typedef enum logic [2:0] {
    UEFS_RX_IDLE, UEFS_RX_START, UEFS_RX_DATA, UEFS_RX_PAR, UEFS_RX_STOP, UEFS_RX_WAIT
  } uefs_rx_state_type;
  typedef enum logic [2:0] {
    UEFS_TX_IDLE, UEFS_TX_START, UEFS_TX_DATA, UEFS_TX_PAR, UEFS_TX_STOP
  } uefs_tx_state_type;

  // index of the last data bit for a word length code
  function automatic logic [2:0] uefs_last_idx(input logic [1:0] wlen);
    uefs_last_idx = 3'h4 + {1'b0, wlen};
  endfunction

  // parity bit expected on the line
  function automatic logic uefs_parity(input logic [7:0] d, input logic [1:0] wlen,
                                       input logic even_sel, input logic stick_sel);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - wlen));
    if (stick_sel) begin
      uefs_parity = ~even_sel;
    end else begin
      uefs_parity = even_sel ? ^m : ~^m;
    end
  endfunction
endpackage

// [uefs_fifo.sv]
// character fifo that shrinks to one entry when the fifo is disabled
`timescale 1ns/10ps
module uefs_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         clk_sys_i,  // system clock
  input  wire logic         nrst_i,     // async reset, low
  input  wire logic         fifo_en_i,  // full depth when high
  input  wire logic         push_i,     // write one entry
  input  wire logic [W-1:0] push_data_i,// entry written
  input  wire logic         pop_i,      // drop head entry
  output logic      [W-1:0] head_o,     // head entry
  output logic              empty_o,    // no entry
  output logic              full_o      // no room
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
  } uefs_fifo_state_type;

  uefs_fifo_state_type st_reg;
  uefs_fifo_state_type st_next;
  logic [AW:0]         limit;

  // single entry when disabled
  assign limit   = fifo_en_i ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign empty_o = (st_reg.cnt == '0);
  assign full_o  = (st_reg.cnt >= limit);
  assign head_o  = st_reg.mem[st_reg.rptr];

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push_i && !full_o) begin
      st_next.mem[st_reg.wptr] = push_data_i;
      st_next.wptr = st_reg.wptr + AW'(1);
    end
    if (pop_i && !empty_o) begin
      st_next.rptr = st_reg.rptr + AW'(1);
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push_i && !full_o) - (AW+1)'(pop_i && !empty_o);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // uefs_fifo

// [uefs_tx.sv]
// transmit shifter with parity generation
`timescale 1ns/10ps
`include "uefs_defs.svh"
module uefs_tx
  import uefs_pkg::*;
(
  input  wire logic        clk_sys_i, // system clock
  input  wire logic        nrst_i,    // async reset, low
  input  wire logic        valid_i,   // character waiting
  input  wire logic [7:0]  data_i,    // character to send
  input  wire logic [7:0]  lcr_i,     // line_control
  input  wire logic [15:0] div_i,     // clocks per bit
  output logic             take_o,    // character taken
  output logic             busy_o,    // shifting
  output logic             tx_line_o  // serial output
);
  typedef struct packed {
    uefs_tx_state_type state;
    logic [15:0]       cnt;
    logic [2:0]        idx;
    logic [7:0]        shift;
    logic              par;
    logic              txd;
  } uefs_tx_state_reg_type;

  uefs_tx_state_reg_type st_reg;
  uefs_tx_state_reg_type st_next;
  logic                  bit_end;

  assign bit_end   = (st_reg.cnt == 16'h0000);
  assign take_o    = (st_reg.state == UEFS_TX_IDLE) && valid_i;
  assign busy_o    = (st_reg.state != UEFS_TX_IDLE);
  assign tx_line_o = st_reg.txd;

  // frame sequencing
  always_comb begin
    st_next = st_reg;
    if (!bit_end) begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
    case (st_reg.state)
      UEFS_TX_IDLE: if (valid_i) begin
        st_next.shift = data_i;
        st_next.par   = uefs_parity(data_i, lcr_i[`UEFS_LCR_WHI:`UEFS_LCR_WLO],
                                    lcr_i[`UEFS_LCR_EVEN], lcr_i[`UEFS_LCR_STICK]);
        st_next.state = UEFS_TX_START;
        st_next.txd   = 1'b0;
        st_next.cnt   = div_i - 16'h0001;
      end
      UEFS_TX_START: if (bit_end) begin
        st_next.state = UEFS_TX_DATA;
        st_next.idx   = 3'h0;
        st_next.txd   = st_reg.shift[0];
        st_next.cnt   = div_i - 16'h0001;
      end
      UEFS_TX_DATA: if (bit_end) begin
        st_next.cnt = div_i - 16'h0001;
        if (st_reg.idx == uefs_last_idx(lcr_i[`UEFS_LCR_WHI:`UEFS_LCR_WLO])) begin
          st_next.state = lcr_i[`UEFS_LCR_PEN] ? UEFS_TX_PAR : UEFS_TX_STOP;
          st_next.txd   = lcr_i[`UEFS_LCR_PEN] ? st_reg.par : 1'b1;
        end else begin
          st_next.idx = st_reg.idx + 3'h1;
          st_next.txd = st_reg.shift[st_reg.idx + 3'h1];
        end
      end
      UEFS_TX_PAR: if (bit_end) begin
        st_next.state = UEFS_TX_STOP;
        st_next.txd   = 1'b1;
        st_next.cnt   = div_i - 16'h0001;
      end
      default: if (bit_end) begin
        st_next.state = UEFS_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{state: UEFS_TX_IDLE, txd: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // uefs_tx

// [uefs_top.sv]
// uart receive error status, line flags, receiver and register port
// What this block does
// - break flag when line low past frame
// - error-clear write zeroes break, parity, framing
// - one zero character pushed per break
// - after break wait high then start
// - parity flag on parity mismatch
// - framing flag when stop bit low
// - error flags travel with fifo character
// - ring flag is inverted ring input
// - tx empty resets one, fifo or holding
// - tx empty ignores the shift register
// - rx full resets zero, fifo or holding
// - tx full resets zero, fifo or holding
// - overrun keeps fifo, flag cleared by clear
// - stick parity fixed by even select
`timescale 1ns/10ps
`include "uefs_defs.svh"
module uefs_top
  import uefs_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic        clk_sys_i,            // system clock
  input  wire logic        nrst_i,               // async reset, low
  input  wire logic [7:0]  reg_addr_i,           // register byte address
  input  wire logic [31:0] reg_wdata_i,          // write data
  input  wire logic        reg_wr_i,             // write strobe
  input  wire logic        reg_rd_i,             // read strobe
  output logic      [31:0] reg_rdata_o,          // read data, next cycle
  input  wire logic        rx_line_i,            // serial input
  output logic             tx_line_o,            // serial output
  input  wire logic        modem_bell_input_n_i, // ring input, low
  output logic             irq_o                 // interrupt, level
);
  typedef struct packed {
    uefs_rx_state_type rx_state;
    logic [15:0]       rx_cnt;
    logic [2:0]        rx_idx;
    logic [7:0]        rx_shift;
    logic              rx_par;
    logic [3:0]        rsr;
    logic [7:0]        lcr;
    logic [15:0]       div;
    logic [3:0]        istat;
    logic [3:0]        imask;
    logic [31:0]       rdata;
  } uefs_top_state_type;

  uefs_top_state_type st_reg;
  uefs_top_state_type st_next;
  logic        rx_push;
  logic [10:0] rx_entry;
  logic        rx_pop;
  logic [10:0] rx_head;
  logic        rx_empty;
  logic        rx_full;
  logic        tx_push;
  logic [7:0]  tx_head;
  logic        tx_empty;
  logic        tx_full;
  logic        tx_take;
  logic        tx_busy;
  logic        ovr_evt;
  logic        brk_evt;
  logic        frame_end;
  logic [3:0]  err_evt;
  logic        bit_end;
  logic        pen;
  logic        fifo_on;
  logic [1:0]  wlen;
  logic [8:0]  flags;

  assign pen     = st_reg.lcr[`UEFS_LCR_PEN];
  assign fifo_on = st_reg.lcr[`UEFS_LCR_FIFO];
  assign wlen    = st_reg.lcr[`UEFS_LCR_WHI:`UEFS_LCR_WLO];
  assign bit_end = (st_reg.rx_cnt == 16'h0000);
  assign reg_rdata_o = st_reg.rdata;
  assign irq_o   = |(st_reg.istat & st_reg.imask);

  // flag word: ring, tx empty, rx full, tx full, rx empty, busy
  assign flags = {~modem_bell_input_n_i,
                  tx_empty,
                  rx_full,
                  tx_full,
                  rx_empty, tx_busy || !tx_empty, 3'h0};

  // receive fifo, each entry holds break, parity, framing and data
  uefs_fifo #(.W(11), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .fifo_en_i   (fifo_on),
    .push_i      (rx_push),
    .push_data_i (rx_entry),
    .pop_i       (rx_pop),
    .head_o      (rx_head),
    .empty_o     (rx_empty),
    .full_o      (rx_full)
  );

  // transmit fifo
  uefs_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .fifo_en_i   (fifo_on),
    .push_i      (tx_push),
    .push_data_i (reg_wdata_i[7:0]),
    .pop_i       (tx_take),
    .head_o      (tx_head),
    .empty_o     (tx_empty),
    .full_o      (tx_full)
  );

  uefs_tx u_tx (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .valid_i   (!tx_empty),
    .data_i    (tx_head),
    .lcr_i     (st_reg.lcr),
    .div_i     (st_reg.div),
    .take_o    (tx_take),
    .busy_o    (tx_busy),
    .tx_line_o (tx_line_o)
  );

  // receiver, register port, sticky status
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 32'h0000_0000;
    rx_push  = 1'b0;
    rx_entry = 11'h000;
    rx_pop   = 1'b0;
    tx_push  = 1'b0;
    ovr_evt  = 1'b0;
    brk_evt  = 1'b0;
    frame_end = 1'b0;
    if (!bit_end) begin
      st_next.rx_cnt = st_reg.rx_cnt - 16'h0001;
    end
    case (st_reg.rx_state)
      UEFS_RX_IDLE: if (!rx_line_i) begin
        st_next.rx_state = UEFS_RX_START;
        st_next.rx_cnt   = st_reg.div >> 1;
      end
      UEFS_RX_START: if (bit_end) begin
        st_next.rx_state = rx_line_i ? UEFS_RX_IDLE : UEFS_RX_DATA;
        st_next.rx_idx   = 3'h0;
        st_next.rx_shift = 8'h00;
        st_next.rx_cnt   = st_reg.div - 16'h0001;
      end
      UEFS_RX_DATA: if (bit_end) begin
        st_next.rx_shift[st_reg.rx_idx] = rx_line_i;
        st_next.rx_cnt = st_reg.div - 16'h0001;
        if (st_reg.rx_idx == uefs_last_idx(wlen)) begin
          st_next.rx_state = pen ? UEFS_RX_PAR : UEFS_RX_STOP;
        end else begin
          st_next.rx_idx = st_reg.rx_idx + 3'h1;
        end
      end
      UEFS_RX_PAR: if (bit_end) begin
        st_next.rx_par   = rx_line_i;
        st_next.rx_state = UEFS_RX_STOP;
        st_next.rx_cnt   = st_reg.div - 16'h0001;
      end
      UEFS_RX_STOP: if (bit_end) begin
        frame_end = 1'b1;
        // low through start, data, parity and stop
        brk_evt = (st_reg.rx_shift == 8'h00) && !rx_line_i
                  && !(pen && st_reg.rx_par);
        if (brk_evt) begin
          rx_entry = 11'h400;
          st_next.rx_state = UEFS_RX_WAIT;
        end else begin
          rx_entry[`UEFS_RSR_FRM+8] = !rx_line_i;
          rx_entry[`UEFS_RSR_PAR+8] = pen && (st_reg.rx_par !=
            uefs_parity(st_reg.rx_shift, wlen, st_reg.lcr[`UEFS_LCR_EVEN],
                        st_reg.lcr[`UEFS_LCR_STICK]));
          rx_entry[7:0] = st_reg.rx_shift;
          st_next.rx_state = UEFS_RX_IDLE;
        end
        // full fifo keeps its contents, character lost
        ovr_evt = rx_full;
        rx_push = !rx_full;
      end
      default: if (rx_line_i) begin
        st_next.rx_state = UEFS_RX_IDLE;
      end
    endcase

    // register writes
    if (reg_wr_i) begin
      if (reg_addr_i == `UEFS_OFF_DATA) begin
        tx_push = !tx_full;
      end else if (reg_addr_i == `UEFS_OFF_RSR) begin
        st_next.rsr = 4'h0;
      end else if (reg_addr_i == `UEFS_OFF_DIV) begin
        st_next.div = reg_wdata_i[15:0];
      end else if (reg_addr_i == `UEFS_OFF_LCR) begin
        st_next.lcr = reg_wdata_i[7:0];
      end else if (reg_addr_i == `UEFS_OFF_ISTAT) begin
        st_next.istat = st_reg.istat & ~reg_wdata_i[3:0];
      end else if (reg_addr_i == `UEFS_OFF_IMASK) begin
        st_next.imask = reg_wdata_i[3:0];
      end
    end else if (reg_rd_i) begin
      if (reg_addr_i == `UEFS_OFF_DATA) begin
        rx_pop = !rx_empty;
        st_next.rdata = {20'h00000, st_reg.rsr[`UEFS_RSR_OE], rx_head};
        // head character's errors move into the status
        if (!rx_empty) begin
          st_next.rsr[2:0] = st_reg.rsr[2:0] | rx_head[10:8];
        end
      end else if (reg_addr_i == `UEFS_OFF_RSR) begin
        st_next.rdata = {28'h0000000, st_reg.rsr};
      end else if (reg_addr_i == `UEFS_OFF_FLAG) begin
        st_next.rdata = {23'h000000, flags};
      end else if (reg_addr_i == `UEFS_OFF_DIV) begin
        st_next.rdata = {16'h0000, st_reg.div};
      end else if (reg_addr_i == `UEFS_OFF_LCR) begin
        st_next.rdata = {24'h000000, st_reg.lcr};
      end else if (reg_addr_i == `UEFS_OFF_ISTAT) begin
        st_next.rdata = {28'h0000000, st_reg.istat};
      end else if (reg_addr_i == `UEFS_OFF_IMASK) begin
        st_next.rdata = {28'h0000000, st_reg.imask};
      end
    end

    // sticky sets after clears, so a set wins
    if (ovr_evt) begin
      st_next.rsr[`UEFS_RSR_OE] = 1'b1;
    end
    st_next.istat = st_next.istat | err_evt;
  end

  // interrupt events: overrun, break, parity, framing
  assign err_evt = {ovr_evt, frame_end ? rx_entry[10:8] : 3'h0};

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{rx_state: UEFS_RX_IDLE, lcr: `UEFS_LCR_RST,
                  div: `UEFS_DIV_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_flag_bell_read: assert property (
    reg_rd_i && reg_addr_i == `UEFS_OFF_FLAG
    |=> reg_rdata_o[8] == !$past(modem_bell_input_n_i))
    else $error("ring flag not inverse of ring input");

  chk_error_clear: assert property (
    reg_wr_i && reg_addr_i == `UEFS_OFF_RSR && !ovr_evt |=> st_reg.rsr == 4'h0)
    else $error("error clear write left a flag set");

  chk_break_once: assert property (
    brk_evt |-> rx_push || ovr_evt ##1 st_reg.rx_state == UEFS_RX_WAIT ##1 !frame_end)
    else $error("break did not load one character and wait");

  chk_wait_high: assert property (
    st_reg.rx_state == UEFS_RX_WAIT && !rx_line_i |=> st_reg.rx_state == UEFS_RX_WAIT)
    else $error("receiver left break wait with line low");

  chk_frame_error: assert property (
    rx_push && !brk_evt |-> rx_entry[8] == !rx_line_i)
    else $error("framing flag disagrees with stop bit");

  chk_parity_off: assert property (
    rx_push && !pen |-> !rx_entry[9])
    else $error("parity flag set with parity off");

  chk_overrun_keep: assert property (
    frame_end && rx_full && !rx_pop && !reg_wr_i
    |-> !rx_push ##1 st_reg.rsr[`UEFS_RSR_OE] && rx_full)
    else $error("overrun lost fifo contents or flag");

  chk_tx_single: assert property (
    !fifo_on |-> tx_full == !tx_empty)
    else $error("tx holding flags not complementary");

  chk_rx_single: assert property (
    !fifo_on |-> rx_full == !rx_empty)
    else $error("rx holding flags not complementary");

  cov_break:   cover property (brk_evt ##[1:100] rx_line_i);
  cov_overrun: cover property (ovr_evt);
  cov_parity:  cover property (rx_push && rx_entry[9]);
  cov_tx_take: cover property (tx_take ##[1:200] !tx_busy);
endmodule // uefs_top

// [uefs_peer.sv]
// serial peer model: drives the receive line and decodes the transmit line
`timescale 1ns/10ps
module uefs_peer #(
  parameter int DIV = 4
) (
  input  wire logic clk_sys_i, // system clock
  output logic      rx_line_o, // to design serial input
  input  wire logic tx_line_i  // from design serial output
);
  // line idles at the marking level
  initial rx_line_o = 1'b1;

  // one bit held for DIV clocks, changed just after an edge
  task automatic put_bit(input logic b);
    rx_line_o <= b;
    repeat (DIV) @(posedge clk_sys_i);
  endtask

  // start, data lsb first, optional parity, one stop, then idle
  task automatic send(input logic [7:0] d, input int nb, input logic pen,
                      input logic pb, input logic sb);
    @(posedge clk_sys_i);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++) begin
      put_bit(d[i]);
    end
    if (pen) begin
      put_bit(pb);
    end
    put_bit(sb);
    repeat (2) put_bit(1'b1);
  endtask

  // line held low for n clocks, then back to marking
  task automatic brk(input int n);
    @(posedge clk_sys_i);
    rx_line_o <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    repeat (2) put_bit(1'b1);
  endtask

  // decode one frame from the transmit line, unknown on timeout
  task automatic recv(input int nb, output logic [7:0] d);
    int n;
    n = 0;
    d = 8'h00;
    while (tx_line_i !== 1'b0 && n < 4000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    repeat (DIV / 2) @(posedge clk_sys_i);
    for (int i = 0; i < nb; i++) begin
      repeat (DIV) @(posedge clk_sys_i);
      #1 d[i] = tx_line_i;
    end
    if (n >= 4000) begin
      d = 8'hXX;
    end
  endtask
endmodule // uefs_peer

// [uefs_top_tb.sv]
// self-checking bench of the uart status block
`timescale 1ns/10ps
`include "uefs_defs.svh"
module uefs_top_tb;
  localparam int DIV = 4;
  localparam int DEPTH = 4;
  // parity cases: line_control, parity bit sent, parity flag expected
  localparam logic [63:0] PLCR = 64'hE6E6_E2E2_6262_6666;
  localparam logic [7:0]  PBIT = 8'h96;
  localparam logic [7:0]  PERR = 8'hAA;
  logic        clk_sys_i            = 1'b0;
  logic        nrst_i               = 1'b0;
  logic [7:0]  reg_addr_i           = 8'h00;
  logic [31:0] reg_wdata_i          = 32'h0;
  logic        reg_wr_i             = 1'b0;
  logic        reg_rd_i             = 1'b0;
  logic        modem_bell_input_n_i = 1'b1;
  logic [31:0] reg_rdata_o;
  logic        rx_line_i;
  logic        tx_line_o;
  logic        irq_o;
  logic [7:0]  rx;
  int          n_errors = 0;
  int          checks   = 0;

  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  uefs_top #(.DEPTH(DEPTH)) u_uefs_top (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_line_i(rx_line_i), .tx_line_o(tx_line_o),
    .modem_bell_input_n_i(modem_bell_input_n_i), .irq_o(irq_o)
  );
  uefs_peer #(.DIV(DIV)) u_uefs_peer (
    .clk_sys_i(clk_sys_i), .rx_line_o(rx_line_i), .tx_line_i(tx_line_o)
  );

  task automatic summarize();
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, idle edge before the next access
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data taken in the cycle after the strobe edge, masked compare
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o & m, e);
  endtask

  // bounded wait on the flag register
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    checks--;
    rc(`UEFS_OFF_FLAG, 32'h0, 32'h0);
    while ((reg_rdata_o & m) !== e && n < 500) begin
      checks--;
      rc(`UEFS_OFF_FLAG, 32'h0, 32'h0);
      n++;
    end
    if (n >= 500) begin
      n_errors++;
      $display("mismatch at %0t: flag wait ran out", $time);
      summarize();
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // reset values, unmapped read, ring input
    rc(`UEFS_OFF_FLAG, 32'hFFFFFFFF, 32'h90);
    rc(`UEFS_OFF_RSR, 32'hFFFFFFFF, 32'h0);
    rc(`UEFS_OFF_LCR, 32'hFFFFFFFF, 32'h0);
    rc(`UEFS_OFF_DIV, 32'hFFFFFFFF, 32'h10);
    rc(8'h7C, 32'hFFFFFFFF, 32'h0);
    @(posedge clk_sys_i) modem_bell_input_n_i <= 1'b0;
    rc(`UEFS_OFF_FLAG, 32'h100, 32'h100);
    @(posedge clk_sys_i) modem_bell_input_n_i <= 1'b1;
    rc(`UEFS_OFF_FLAG, 32'h100, 32'h0);
    wr(`UEFS_OFF_DIV, 32'(DIV));
    // every word length, single-entry holding register
    for (int w = 0; w < 4; w++) begin
      wr(`UEFS_OFF_LCR, 32'(w) << 5);
      u_uefs_peer.send(8'hB7, 5 + w, 1'b0, 1'b0, 1'b1);
      rc(`UEFS_OFF_FLAG, 32'h50, 32'h40);
      rc(`UEFS_OFF_DATA, 32'hFFF, 32'hB7 & (32'hFF >> (3 - w)));
      rc(`UEFS_OFF_FLAG, 32'h50, 32'h10);
    end
    // low stop bit
    wr(`UEFS_OFF_LCR, 32'h60);
    u_uefs_peer.send(8'hA5, 8, 1'b0, 1'b0, 1'b0);
    rc(`UEFS_OFF_DATA, 32'hFFF, 32'h1A5);
    rc(`UEFS_OFF_RSR, 32'hF, 32'h1);
    wr(`UEFS_OFF_RSR, 32'h0);
    rc(`UEFS_OFF_RSR, 32'hF, 32'h0);
    // even, odd and both stick settings, right and wrong parity
    for (int i = 0; i < 8; i++) begin
      wr(`UEFS_OFF_LCR, {24'h0, PLCR[i*8 +: 8]});
      u_uefs_peer.send(8'h96, 8, 1'b1, PBIT[i], 1'b1);
      rc(`UEFS_OFF_DATA, 32'hFFF, {22'h0, PERR[i], 9'h096});
      rc(`UEFS_OFF_RSR, 32'hF, {30'h0, PERR[i], 1'b0});
      wr(`UEFS_OFF_RSR, 32'h0);
    end
    // interrupt raised, masked and cleared
    wr(`UEFS_OFF_ISTAT, 32'hF);
    wr(`UEFS_OFF_IMASK, 32'h0);
    u_uefs_peer.send(8'h96, 8, 1'b1, 1'b1, 1'b1);
    rc(`UEFS_OFF_ISTAT, 32'hF, 32'h2);
    #1 chk({31'h0, irq_o}, 32'h0);
    wr(`UEFS_OFF_IMASK, 32'h1);
    #1 chk({31'h0, irq_o}, 32'h0);
    wr(`UEFS_OFF_IMASK, 32'h2);
    #1 chk({31'h0, irq_o}, 32'h1);
    wr(`UEFS_OFF_ISTAT, 32'h2);
    #1 chk({31'h0, irq_o}, 32'h0);
    rc(`UEFS_OFF_DATA, 32'hFFF, 32'h296);
    wr(`UEFS_OFF_RSR, 32'h0);
    // overrun with the fifo on: contents kept, flag cleared
    wr(`UEFS_OFF_LCR, 32'h70);
    for (int i = 0; i <= DEPTH; i++) begin
      u_uefs_peer.send(8'h40 + 8'(i), 8, 1'b0, 1'b0, 1'b1);
    end
    rc(`UEFS_OFF_FLAG, 32'h50, 32'h40);
    rc(`UEFS_OFF_RSR, 32'h8, 32'h8);
    for (int i = 0; i < DEPTH; i++) begin
      rc(`UEFS_OFF_DATA, 32'hFF, 32'h40 + 32'(i));
    end
    rc(`UEFS_OFF_FLAG, 32'h50, 32'h10);
    wr(`UEFS_OFF_RSR, 32'h0);
    rc(`UEFS_OFF_RSR, 32'hF, 32'h0);
    // error flags travel with their own fifo entry
    wr(`UEFS_OFF_LCR, 32'h76);
    for (int i = 0; i < 3; i++) begin
      u_uefs_peer.send(8'h11 * 8'(i + 1), 8, 1'b1, i == 1, 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      rc(`UEFS_OFF_DATA, 32'h7FF, {22'h0, i == 1, 1'b0, 8'h11 * 8'(i + 1)});
    end
    rc(`UEFS_OFF_RSR, 32'hF, 32'h2);
    wr(`UEFS_OFF_RSR, 32'h0);
    // long break: one zero entry, then a normal character
    u_uefs_peer.brk(3 * 11 * DIV);
    rc(`UEFS_OFF_DATA, 32'h4FF, 32'h400);
    rc(`UEFS_OFF_FLAG, 32'h10, 32'h10);
    rc(`UEFS_OFF_RSR, 32'h4, 32'h4);
    wr(`UEFS_OFF_RSR, 32'h0);
    rc(`UEFS_OFF_RSR, 32'hF, 32'h0);
    u_uefs_peer.send(8'h5A, 8, 1'b1, 1'b0, 1'b1);
    rc(`UEFS_OFF_DATA, 32'h7FF, 32'h05A);
    // transmit with the holding register: full, then empty while shifting
    wr(`UEFS_OFF_LCR, 32'h60);
    fork
      u_uefs_peer.recv(8, rx);
      begin
        wr(`UEFS_OFF_DATA, 32'hC3);
        wr(`UEFS_OFF_DATA, 32'h3C);
        rc(`UEFS_OFF_FLAG, 32'hA8, 32'h28);
      end
    join
    chk({24'h0, rx}, 32'hC3);
    // no start bit seen on the transmit line: end the run
    if (rx === 8'hXX) begin
      summarize();
    end
    poll(32'h80, 32'h80);
    rc(`UEFS_OFF_FLAG, 32'h88, 32'h88);
    // transmit fifo filled past its depth
    poll(32'h08, 32'h00);
    wr(`UEFS_OFF_LCR, 32'h70);
    for (int i = 0; i <= DEPTH + 1; i++) begin
      wr(`UEFS_OFF_DATA, 32'(i));
    end
    rc(`UEFS_OFF_FLAG, 32'hA0, 32'h20);
    summarize();
  end
endmodule // uefs_top_tb
